// *** tb/pac_cmd_assertions.sv ***
// pac_cmd_assertions.sv: port-level checks of the command block
// assumes: bound to pac_cmd, one clock, async active-high reset
`timescale 1ns/1ps
`default_nettype none
module pac_cmd_assertions #(
  parameter logic [6:0] DEF_ADDR = 7'h40
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rx_valid,
  input wire logic i_rx_stop,
  input wire logic i_tx_start,
  input wire logic i_tx_req,
  input wire pac_pkg::pac_byte_t o_tx_data,
  input wire logic o_rd_ready,
  input wire logic [6:0] o_bus_addr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata
);
  import pac_pkg::*;
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_addr_once: assert property ($changed(o_bus_addr) |-> $past(o_bus_addr) == DEF_ADDR)
    else $error("bus address changed twice");
  a_ready_drop: assert property (i_rx_valid |=> !o_rd_ready)
    else $error("ready kept during new frame");
  a_ready_quiet: assert property (i_rx_stop |=> !o_rd_ready [*3])
    else $error("ready too soon after stop");
  a_tx_hold: assert property (!i_tx_req && !i_tx_start |=> $stable(o_tx_data))
    else $error("read byte changed without request");
  a_status_addr: assert property (i_reg_rd && i_reg_addr == 8'h00 |=>
    o_reg_rdata[6:0] == $past(o_bus_addr) && o_reg_rdata[31:24] == 8'h00)
    else $error("status address field wrong");
  a_prot_bits: assert property (i_reg_rd && i_reg_addr inside {8'h10, 8'h14, 8'h18,
    8'h1c, 8'h20, 8'h24} |=> (o_reg_rdata & 32'hffffffdd) == 32'h0)
    else $error("protection byte has stray bits");
  a_sel_rw: assert property (i_reg_wr && i_reg_addr == 8'h04 ##1 i_reg_rd &&
    i_reg_addr == 8'h04 |=> o_reg_rdata[4:0] == $past(i_reg_wdata[4:0], 2))
    else $error("selector readback wrong");
  c_ready: cover property ($rose(o_rd_ready));
  c_addr: cover property ($changed(o_bus_addr));
  c_prot: cover property (i_reg_rd && i_reg_addr == 8'h14);
endmodule // pac_cmd_assertions
bind pac_cmd pac_cmd_assertions #(.DEF_ADDR(DEF_ADDR)) chk_u (.i_clk(i_clk),
  .i_rst(i_rst), .i_rx_valid(i_rx_valid), .i_rx_stop(i_rx_stop),
  .i_tx_start(i_tx_start), .i_tx_req(i_tx_req), .o_tx_data(o_tx_data),
  .o_rd_ready(o_rd_ready), .o_bus_addr(o_bus_addr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata));
`default_nettype wire

// *** tb/pac_host_model.sv ***
// pac_host_model.sv: host side, sends command frames and reads results
// assumes: same clock as the block, called through its tasks
`timescale 1ns/1ps
`default_nettype none
module pac_host_model (
  input wire logic i_clk,
  input wire logic i_rd_ready,
  input wire pac_pkg::pac_byte_t i_tx_data,
  output logic o_rx_valid,
  output pac_pkg::pac_byte_t o_rx_data,
  output logic o_rx_stop,
  output logic o_tx_start,
  output logic o_tx_req
);
  import pac_pkg::*;
  pac_byte_t rx [0:47];
  logic got_ready;
  initial begin
    {o_rx_valid, o_rx_stop, o_tx_start, o_tx_req, got_ready} = 5'h00;
    o_rx_data = 8'h00;
  end
  // --------------------------------------------------------------------------
  // frame tasks
  // --------------------------------------------------------------------------
  task automatic send(input pac_byte_t c, l, p0, p1, input int np);
    pac_byte_t b [4];
    b = '{c, l, p0, p1};
    for (int i = 0; i < np + 2; i++) begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_data <= b[i];
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_stop <= 1'b1;
    o_rx_data <= ~b[np + 1];
    @(posedge i_clk);
    o_rx_stop <= 1'b0;
  endtask
  task automatic fetch(input int n);
    int w;
    w = 0;
    while (!i_rd_ready && w < 2000) begin
      @(posedge i_clk);
      w++;
    end
    got_ready = i_rd_ready;
    @(posedge i_clk);
    o_tx_start <= 1'b1;
    @(posedge i_clk);
    o_tx_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_tx_req <= 1'b1;
      @(posedge i_clk);
      o_tx_req <= 1'b0;
      #1 rx[i] = i_tx_data;
    end
  endtask
endmodule // pac_host_model
`default_nettype wire

// *** tb/tb_pac_cmd.sv ***
// tb_pac_cmd.sv: self-checking bench of the command block
// assumes: short duration parameters, host model on the command link
`timescale 1ns/1ps
`default_nettype none
module tb_pac_cmd;
  import pac_pkg::*;
  typedef struct {
    pac_byte_t c, l, p0, p1;
    int np;
    pac_byte_t res, rl;
    pac_cfg_t d;
  } pac_row_s;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic rx_valid, rx_stop, tx_start, tx_req, rd_ready;
  pac_byte_t rx_data, tx_data;
  logic [6:0] bus_addr;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  int miscompares = 0, checks_done = 0;
  logic [7:0] prot_exp [6] = '{8'h02, 8'h02, 8'h20, 8'h02, 8'h00, 8'h02};
  pac_row_s rows [16] = '{
    '{8'hc3, 8'h02, 8'h00, 8'h02, 2, 8'haa, 8'h01, 16'h0},
    '{8'hc3, 8'h02, 8'h00, 8'h20, 2, 8'h55, 8'h01, 16'h0},
    '{8'hc3, 8'h02, 8'h01, 8'h20, 2, 8'h55, 8'h01, 16'h0},
    '{8'hc3, 8'h02, 8'h02, 8'h22, 2, 8'h77, 8'h01, 16'h0},
    '{8'hc3, 8'h02, 8'h02, 8'h00, 2, 8'h77, 8'h01, 16'h0},
    '{8'hc3, 8'h02, 8'h02, 8'h20, 2, 8'haa, 8'h01, 16'h0},
    '{8'hc3, 8'h02, 8'h02, 8'h02, 2, 8'h55, 8'h01, 16'h0},
    '{8'hc3, 8'h02, 8'h06, 8'h02, 2, 8'h77, 8'h01, 16'h0},
    '{8'hc3, 8'h02, 8'h14, 8'h02, 2, 8'h77, 8'h01, 16'h0},
    '{8'hc3, 8'h01, 8'h04, 8'h02, 1, 8'h77, 8'h01, 16'h0},
    '{8'h75, 8'h01, 8'ha0, 8'h00, 1, 8'haa, 8'h01, 16'h0},
    '{8'h75, 8'h01, 8'hb0, 8'h00, 1, 8'h55, 8'h01, 16'h0},
    '{8'h52, 8'h01, 8'h00, 8'h00, 1, 8'haa, 8'h03, 16'h0000},
    '{8'h52, 8'h01, 8'h13, 8'h00, 1, 8'haa, 8'h03, 16'h5828},
    '{8'h52, 8'h01, 8'h11, 8'h00, 1, 8'haa, 8'h03, 16'h803c},
    '{8'h52, 8'h01, 8'h12, 8'h00, 1, 8'haa, 8'h03, 16'h0006}};
  always #5 i_clk = ~i_clk;
  pac_cmd #(.WS_CYCLES(5), .OP_CYCLES(3)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_stop(rx_stop),
    .i_tx_start(tx_start), .i_tx_req(tx_req), .o_tx_data(tx_data),
    .o_rd_ready(rd_ready), .o_bus_addr(bus_addr), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata));
  pac_host_model host_u (.i_clk(i_clk), .i_rd_ready(rd_ready), .i_tx_data(tx_data),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_stop(rx_stop),
    .o_tx_start(tx_start), .o_tx_req(tx_req));
  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_wrt(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic reg_read(logic [7:0] a);
    @(posedge i_clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic run(pac_byte_t c, l, p0, p1, int np, int nb);
    host_u.send(c, l, p0, p1, np);
    host_u.fetch(nb);
    check("ready", host_u.got_ready, 1'b1);
  endtask
  function automatic pac_cfg_t cfg_def(int r);
    if (r == 0) return 16'h0000;
    if (r == 17) return 16'h803c;
    if (r == 19) return 16'h5828;
    return 16'h0006;
  endfunction
  task automatic close_out;
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    reg_read(8'h00);
    check("status", rd_val & 32'h7ff, 32'h40);
    for (int p = 0; p < 6; p++) begin
      reg_read(8'h10 + 8'(4 * p));
      check("prot", rd_val, (p % 2) ? 32'h2 : 32'h0);
    end
    foreach (rows[i]) begin
      run(rows[i].c, rows[i].l, rows[i].p0, rows[i].p1, rows[i].np, rows[i].rl + 1);
      check("len", host_u.rx[0], rows[i].rl);
      check("result", host_u.rx[1], rows[i].res);
      if (rows[i].rl == 8'h03) check("cfg", {host_u.rx[3], host_u.rx[2]}, rows[i].d);
    end
    check("addr", bus_addr, 7'h50);
    reg_read(8'h00);
    check("status", rd_val[23:8], 16'haa05);
    for (int p = 0; p < 6; p++) begin
      reg_read(8'h10 + 8'(4 * p));
      check("prot", rd_val, prot_exp[p]);
    end
    run(8'h52, 8'h01, 8'hff, 8'h00, 1, 42);
    check("len", host_u.rx[0], 8'd41);
    for (int r = 0; r < 20; r++) begin
      check("cfg", {host_u.rx[3 + 2 * r], host_u.rx[2 + 2 * r]}, cfg_def(r));
    end
    reg_wrt(8'h04, 32'h5);
    reg_read(8'h04);
    check("sel", rd_val[4:0], 5'h05);
    reg_wrt(8'h08, 32'h8123);
    reg_read(8'hfc);
    check("unmapped", rd_val, 32'h0);
    run(8'h52, 8'h01, 8'h05, 8'h00, 1, 5);
    check("cfg", {host_u.rx[3], host_u.rx[2]}, 16'h8123);
    check("fill", host_u.rx[4], 8'hff);
    reg_read(8'h08);
    check("cfg_data", rd_val, 32'h8123);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    close_out();
  end
endmodule // tb_pac_cmd
`default_nettype wire

// *** verilog/pac_cfg_mem.sv ***
// pac_cfg_mem.sv: configuration register set, one write port, two registered read ports
// assumes: single clock, reset loads the documented defaults
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.svh"

module pac_cfg_mem #(
  parameter int DEPTH = `PAC_CFG_REGS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire pac_pkg::pac_cfg_t i_wdata,
  input wire logic [4:0] i_raddr_a,
  output pac_pkg::pac_cfg_t o_rdata_a,
  input wire logic [4:0] i_raddr_b,
  output pac_pkg::pac_cfg_t o_rdata_b
);
  import pac_pkg::*;

  if (DEPTH < 1 || DEPTH > 32) begin : g_chk
    $error("pac_cfg_mem: DEPTH must be 1 to 32");
  end

  pac_cfg_t mem_ff [DEPTH];
  pac_cfg_t nxt_mem [DEPTH];
  pac_cfg_t rdata_a_ff;
  pac_cfg_t rdata_b_ff;

  // --------------------------------------------------------------------------
  // default values
  // --------------------------------------------------------------------------
  function automatic pac_cfg_t cfg_default(input int idx);
    pac_cfg_t v;
    v = `PAC_CFG_RST_TIMING;
    if (idx == 0) v = `PAC_CFG_RST_MASTER;
    else if (idx == int'(`PAC_CFG_IDX_PULLUP)) v = `PAC_CFG_RST_PULLUP;
    else if (idx == int'(`PAC_CFG_IDX_SLEW)) v = `PAC_CFG_RST_SLEW;
    else if (idx == int'(`PAC_CFG_IDX_RSVD)) v = `PAC_CFG_RST_RSVD;
    return v;
  endfunction

  function automatic pac_cfg_t rd(input logic [4:0] a, input pac_cfg_t m [DEPTH]);
    pac_cfg_t v;
    v = '0;
    if (int'(a) < DEPTH) v = m[a];
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_mem = mem_ff;
    if (i_we && int'(i_waddr) < DEPTH) nxt_mem[i_waddr] = i_wdata;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= cfg_default(i);
      rdata_a_ff <= 16'h0000;
      rdata_b_ff <= 16'h0000;
    end else begin
      mem_ff <= nxt_mem;
      rdata_a_ff <= rd(i_raddr_a, mem_ff);
      rdata_b_ff <= rd(i_raddr_b, mem_ff);
    end
  end

  assign o_rdata_a = rdata_a_ff;
  assign o_rdata_b = rdata_b_ff;
endmodule // pac_cfg_mem

`default_nettype wire

// *** verilog/pac_cmd.sv ***
// pac_cmd.sv: command handler for address change, page protection and config read
// assumes: an i2c target on the same clock delivers write bytes, stop and read requests
//
// Behaviour
// RULE1: protection bit 1 reads write-protected, others zero
// RULE2: bit 5 locks page against added protection
// RULE3: code 75h, length one, new address byte
// RULE4: address replaced once, kept as new default; reset reloads DEF_ADDR and allows another change
// RULE5: host puts address in bits 7:1
// RULE6: second address change gives 55h; first AAh
// RULE7: host waits duration, reads length then result
// RULE8: code C3h, length two, page then options
// RULE9: already protected page gives 55h, unchanged
// RULE10: invalid option combination gives 77h, unchanged
// RULE11: valid request on free page stores, AAh
// RULE12: host sets all modes in one command; code accepts one mode per command (02h or 20h), 22h gives 77h
// RULE13: page number from bits 3:0, 0 to 5
// RULE14: check free first, then validity, then write
// RULE15: code 52h with one selector byte
// RULE16: selector up to 13h one, above all
// RULE17: returned value uses write layout
// RULE18: config read ends with result AAh
// RULE19: custom flag bit 15, value bits 13:0
// RULE20: registers 0 to 13h with fixed meanings
// RULE21: all registers ascending, low byte first
// RULE22: result read refused until duration ends
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.svh"

module pac_cmd #(
  parameter int WS_CYCLES = `PAC_WS_CYCLES,
  parameter int OP_CYCLES = `PAC_OP_CYCLES,
  parameter logic [6:0] DEF_ADDR = `PAC_DEF_ADDR
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rx_valid,
  input wire pac_pkg::pac_byte_t i_rx_data,
  input wire logic i_rx_stop,
  input wire logic i_tx_start,
  input wire logic i_tx_req,
  output pac_pkg::pac_byte_t o_tx_data,
  output logic o_rd_ready,
  output logic [6:0] o_bus_addr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  import pac_pkg::*;

  if (WS_CYCLES < 1 || OP_CYCLES < 1) begin : g_chk
    $error("pac_cmd: durations must be at least one cycle");
  end

  pac_state_e state_ff, nxt_state;
  pac_byte_t cmd_ff, nxt_cmd;
  pac_byte_t len_ff, nxt_len;
  logic [1:0] cnt_ff, nxt_cnt;
  pac_byte_t p0_ff, nxt_p0;
  pac_byte_t p1_ff, nxt_p1;
  logic [31:0] timer_ff, nxt_timer;
  pac_byte_t result_ff, nxt_result;
  pac_byte_t rlen_ff, nxt_rlen;
  logic all_ff, nxt_all;
  logic [4:0] sel_ff, nxt_sel;
  pac_byte_t ptr_ff, nxt_ptr;
  pac_byte_t tx_data_ff, nxt_tx_data;
  logic rd_ready_ff, nxt_rd_ready;
  logic [6:0] addr_ff, nxt_addr;
  logic addr_set_ff, nxt_addr_set;
  pac_byte_t prot_ff [`PAC_NUM_PAGES];
  pac_byte_t nxt_prot [`PAC_NUM_PAGES];
  logic [4:0] cfg_sel_ff, nxt_cfg_sel;
  logic [31:0] reg_rdata_ff, nxt_reg_rdata;
  pac_cfg_t mem_a, mem_b;
  logic [4:0] mem_raddr_a;
  logic mem_we;
  pac_byte_t data_idx;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // only one protection mode per command is a valid combination
  function automatic logic prot_valid(input pac_byte_t opt);
    return (opt == `PAC_PROT_WP_ONLY) || (opt == `PAC_PROT_NONE_ONLY); // [RULE10]
  endfunction

  function automatic logic [31:0] dur(input int cyc);
    return 32'(cyc - 1);
  endfunction

  // --------------------------------------------------------------------------
  // configuration store
  // --------------------------------------------------------------------------
  assign data_idx = ptr_ff - 8'd2;
  assign mem_raddr_a = all_ff ? data_idx[5:1] : sel_ff; // [RULE21]
  // reserved register and out of range indices are never written
  assign mem_we = i_reg_wr && (i_reg_addr == `PAC_REG_CFG_DATA) &&
                  (cfg_sel_ff < `PAC_CFG_IDX_RSVD);

  pac_cfg_mem #(
    .DEPTH(`PAC_CFG_REGS)
  ) u_cfg_mem (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we(mem_we),
    .i_waddr(cfg_sel_ff),
    .i_wdata(i_reg_wdata[15:0]),
    .i_raddr_a(mem_raddr_a),
    .o_rdata_a(mem_a),
    .i_raddr_b(cfg_sel_ff),
    .o_rdata_b(mem_b)
  ); // [RULE20]

  // --------------------------------------------------------------------------
  // command engine
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_len = len_ff;
    nxt_cnt = cnt_ff;
    nxt_p0 = p0_ff;
    nxt_p1 = p1_ff;
    nxt_timer = timer_ff;
    nxt_result = result_ff;
    nxt_rlen = rlen_ff;
    nxt_all = all_ff;
    nxt_sel = sel_ff;
    nxt_ptr = ptr_ff;
    nxt_tx_data = tx_data_ff;
    nxt_rd_ready = rd_ready_ff;
    nxt_addr = addr_ff;
    nxt_addr_set = addr_set_ff;
    nxt_prot = prot_ff;
    case (state_ff)
      PAC_IDLE, PAC_DONE: begin
        if (i_rx_valid) begin
          nxt_cmd = i_rx_data;
          nxt_rd_ready = 1'b0;
          nxt_state = PAC_LEN;
        end
      end
      PAC_LEN: begin
        if (i_rx_stop) begin
          nxt_state = PAC_IDLE;
        end else if (i_rx_valid) begin
          nxt_len = i_rx_data;
          nxt_cnt = 2'd0;
          nxt_state = (i_rx_data == 8'h00) ? PAC_DRAIN : PAC_PARAM;
        end
      end
      PAC_PARAM: begin
        if (i_rx_stop) begin
          nxt_state = PAC_IDLE;
        end else if (i_rx_valid) begin
          if (cnt_ff == 2'd0) nxt_p0 = i_rx_data;
          else nxt_p1 = i_rx_data;
          nxt_cnt = cnt_ff + 2'd1;
          if ({6'h00, cnt_ff + 2'd1} == len_ff || cnt_ff == 2'd1) nxt_state = PAC_DRAIN;
        end
      end
      PAC_DRAIN: begin
        if (i_rx_stop) begin
          nxt_state = PAC_EXEC;
          nxt_rlen = 8'd1;
          nxt_all = 1'b0;
          nxt_result = `PAC_RES_INVALID;
          nxt_timer = dur(OP_CYCLES);
          if (cmd_ff == `PAC_CMD_SET_ADDR && len_ff == `PAC_LEN_SET_ADDR) begin // [RULE3]
            nxt_timer = dur(WS_CYCLES);
            if (addr_set_ff) begin
              nxt_result = `PAC_RES_LOCKED; // [RULE6]
            end else begin
              nxt_addr = p0_ff[`PAC_ADDR_HI:`PAC_ADDR_LO]; // [RULE4] [RULE5]
              nxt_addr_set = 1'b1;
              nxt_result = `PAC_RES_OK; // [RULE6]
            end
          end else if (cmd_ff == `PAC_CMD_SET_PROT && len_ff == `PAC_LEN_SET_PROT) begin // [RULE8]
            nxt_timer = dur(WS_CYCLES);
            if (p0_ff[7:4] != 4'h0 || p0_ff[`PAC_PAGE_HI:0] >= 4'(`PAC_NUM_PAGES)) begin // [RULE13]
              nxt_result = `PAC_RES_INVALID;
            end else if (prot_ff[p0_ff[2:0]] != 8'h00) begin // [RULE9] [RULE2] [RULE14]
              nxt_result = `PAC_RES_LOCKED;
            end else if (!prot_valid(p1_ff)) begin // [RULE14]
              nxt_result = `PAC_RES_INVALID; // [RULE10]
            end else begin
              nxt_prot[p0_ff[2:0]] = p1_ff; // [RULE11] [RULE14]
              nxt_result = `PAC_RES_OK;
            end
          end else if (cmd_ff == `PAC_CMD_RD_CFG && len_ff == `PAC_LEN_RD_CFG) begin // [RULE15]
            nxt_all = (p0_ff > `PAC_CFG_LAST); // [RULE16]
            nxt_sel = p0_ff[4:0];
            nxt_rlen = (p0_ff > `PAC_CFG_LAST) ? 8'(1 + 2 * `PAC_CFG_REGS) : 8'd3;
            nxt_result = `PAC_RES_OK; // [RULE18]
          end
        end
      end
      PAC_EXEC: begin
        if (timer_ff == 32'd0) begin
          nxt_rd_ready = 1'b1; // [RULE22]
          nxt_ptr = 8'd0;
          nxt_state = PAC_DONE;
        end else begin
          nxt_timer = timer_ff - 32'd1;
        end
      end
      default: nxt_state = PAC_IDLE;
    endcase
    // read transfer: length, result, then data low byte first
    if (state_ff == PAC_DONE) begin
      if (i_tx_start) begin
        nxt_ptr = 8'd0;
      end else if (i_tx_req) begin
        if (ptr_ff == 8'd0) nxt_tx_data = rlen_ff;
        else if (ptr_ff == 8'd1) nxt_tx_data = result_ff;
        else if (data_idx < rlen_ff - 8'd1)
          nxt_tx_data = data_idx[0] ? mem_a[15:8] : mem_a[7:0]; // [RULE17] [RULE19] [RULE21]
        else nxt_tx_data = `PAC_FILL_BYTE;
        if (ptr_ff != 8'hff) nxt_ptr = ptr_ff + 8'd1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= PAC_IDLE;
      cmd_ff <= 8'h00;
      len_ff <= 8'h00;
      cnt_ff <= 2'd0;
      p0_ff <= 8'h00;
      p1_ff <= 8'h00;
      timer_ff <= 32'h0000_0000;
      result_ff <= 8'h00;
      rlen_ff <= 8'h00;
      all_ff <= 1'b0;
      sel_ff <= 5'h00;
      ptr_ff <= 8'h00;
      tx_data_ff <= 8'h00;
      rd_ready_ff <= 1'b0;
      addr_ff <= DEF_ADDR;
      addr_set_ff <= 1'b0;
      for (int i = 0; i < `PAC_NUM_PAGES; i++)
        prot_ff[i] <= i[0] ? `PAC_PROT_RST_ODD : `PAC_PROT_RST_EVEN; // [RULE1] [RULE9]
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      len_ff <= nxt_len;
      cnt_ff <= nxt_cnt;
      p0_ff <= nxt_p0;
      p1_ff <= nxt_p1;
      timer_ff <= nxt_timer;
      result_ff <= nxt_result;
      rlen_ff <= nxt_rlen;
      all_ff <= nxt_all;
      sel_ff <= nxt_sel;
      ptr_ff <= nxt_ptr;
      tx_data_ff <= nxt_tx_data;
      rd_ready_ff <= nxt_rd_ready;
      addr_ff <= nxt_addr;
      addr_set_ff <= nxt_addr_set;
      prot_ff <= nxt_prot;
    end
  end

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_cfg_sel = cfg_sel_ff;
    nxt_reg_rdata = 32'h0000_0000;
    if (i_reg_wr && i_reg_addr == `PAC_REG_CFG_SEL) nxt_cfg_sel = i_reg_wdata[4:0];
    if (i_reg_rd) begin
      if (i_reg_addr == `PAC_REG_STATUS) begin
        nxt_reg_rdata[6:0] = addr_ff;
        nxt_reg_rdata[`PAC_STAT_SET_BIT] = addr_set_ff;
        nxt_reg_rdata[`PAC_STAT_BUSY_BIT] = (state_ff == PAC_EXEC);
        nxt_reg_rdata[`PAC_STAT_RDY_BIT] = rd_ready_ff;
        nxt_reg_rdata[`PAC_STAT_RES_LO +: 8] = result_ff;
      end else if (i_reg_addr == `PAC_REG_CFG_SEL) begin
        nxt_reg_rdata[4:0] = cfg_sel_ff;
      end else if (i_reg_addr == `PAC_REG_CFG_DATA) begin
        nxt_reg_rdata[15:0] = mem_b;
      end else begin
        for (int i = 0; i < `PAC_NUM_PAGES; i++)
          if (i_reg_addr == `PAC_REG_PROT0 + 8'(4 * i))
            nxt_reg_rdata[7:0] = prot_ff[i]; // [RULE1] [RULE2]
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_sel_ff <= 5'h00;
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_sel_ff <= nxt_cfg_sel;
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  assign o_tx_data = tx_data_ff;
  assign o_rd_ready = rd_ready_ff;
  assign o_bus_addr = addr_ff;
  assign o_reg_rdata = reg_rdata_ff;
endmodule // pac_cmd

`default_nettype wire

// *** verilog/pac_defs.svh ***
// pac_defs.svh: offsets, codes, field positions, reset values and timing counts
// assumes: included by bare name from the package and design files
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH

// --------------------------------------------------------------------------
// command codes and result codes
// --------------------------------------------------------------------------
`define PAC_CMD_SET_ADDR 8'h75
`define PAC_CMD_SET_PROT 8'hc3
`define PAC_CMD_RD_CFG 8'h52
`define PAC_LEN_SET_ADDR 8'h01
`define PAC_LEN_SET_PROT 8'h02
`define PAC_LEN_RD_CFG 8'h01
`define PAC_RES_OK 8'haa
`define PAC_RES_LOCKED 8'h55
`define PAC_RES_INVALID 8'h77
`define PAC_FILL_BYTE 8'hff

// --------------------------------------------------------------------------
// protection byte fields and page range
// --------------------------------------------------------------------------
`define PAC_PROT_WP_BIT 1
`define PAC_PROT_NONE_BIT 5
`define PAC_PROT_WP_ONLY 8'h02
`define PAC_PROT_NONE_ONLY 8'h20
`define PAC_PROT_RST_EVEN 8'h00
`define PAC_PROT_RST_ODD 8'h02
`define PAC_NUM_PAGES 6
`define PAC_PAGE_HI 3
`define PAC_ADDR_HI 7
`define PAC_ADDR_LO 1

// --------------------------------------------------------------------------
// configuration register set
// --------------------------------------------------------------------------
`define PAC_CFG_REGS 20
`define PAC_CFG_LAST 8'h13
`define PAC_CFG_CUSTOM_BIT 15
`define PAC_CFG_VAL_HI 13
`define PAC_CFG_RST_MASTER 16'h0000
`define PAC_CFG_RST_TIMING 16'h0006
`define PAC_CFG_RST_PULLUP 16'h803c
`define PAC_CFG_RST_SLEW 16'h0006
`define PAC_CFG_RST_RSVD 16'h5828
`define PAC_CFG_IDX_PULLUP 5'h11
`define PAC_CFG_IDX_SLEW 5'h12
`define PAC_CFG_IDX_RSVD 5'h13

// --------------------------------------------------------------------------
// register port offsets (byte addresses)
// --------------------------------------------------------------------------
`define PAC_REG_STATUS 8'h00
`define PAC_REG_CFG_SEL 8'h04
`define PAC_REG_CFG_DATA 8'h08
`define PAC_REG_PROT0 8'h10
`define PAC_STAT_SET_BIT 8
`define PAC_STAT_BUSY_BIT 9
`define PAC_STAT_RDY_BIT 10
`define PAC_STAT_RES_LO 16

// --------------------------------------------------------------------------
// timing: clock rate, setting-write and operation durations
// --------------------------------------------------------------------------
`define PAC_CLK_MHZ 100
`define PAC_T_WS_US 10000
`define PAC_T_OP_US 40
`define PAC_WS_CYCLES (`PAC_T_WS_US * `PAC_CLK_MHZ)
`define PAC_OP_CYCLES (`PAC_T_OP_US * `PAC_CLK_MHZ)
`define PAC_DEF_ADDR 7'h40

`endif

// *** verilog/pac_pkg.sv ***
// pac_pkg.sv: types of the protection, address and configuration command block
// assumes: pac_defs.svh on the include path
`include "pac_defs.svh"

package pac_pkg;
  typedef enum logic [2:0] {
    PAC_IDLE,
    PAC_LEN,
    PAC_PARAM,
    PAC_DRAIN,
    PAC_EXEC,
    PAC_DONE
  } pac_state_e;

  typedef logic [7:0] pac_byte_t;
  typedef logic [15:0] pac_cfg_t;
endpackage
